/* rtl/vamu_core.sv */
// Purpose: Microcoded vector add, subtract, multiply, averaging and scale
// Assumes: Memory read data valid the cycle after mem_rd
// Notes: Interrupts are taken at element boundaries only
module vamu_core import vamu_pkg::*; (
  input wire logic clk, // 20 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state but the reset synchronizer when low
  input wire logic start, // Issue instruction, taken in idle
  input wire logic [2:0] opcode, // Instruction code
  input wire logic [15:0] arg_ptr, // Argument block address
  input wire logic [15:0] usp, // User stack save area base
  input wire logic irq_req, // Pending interrupt, any source
  input wire logic resume, // Service routine finished
  input wire logic ovf_clr, // Processor clears overflow flag
  input wire logic [15:0] mem_rdata, // Read data, one cycle after read
  output logic mem_rd, // Memory read strobe
  output logic mem_wr, // Memory write strobe
  output logic [15:0] mem_addr, // Memory word address
  output logic [15:0] mem_wdata, // Memory write data
  output logic busy, // Instruction in progress
  output logic done, // Last cycle of instruction
  output logic irq_ack, // Suspended for interrupt service
  output logic trace_inhibit, // Trace interrupt held off
  output logic ovf_flag // Overflow flag
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  vamu_state_type state;
  logic [2:0] op;
  logic [17:0] step;
  logic [15:0] ptr_r, outp, pa, pb, cnt, m, konst, acc, xa, xb, res;
  logic winp;
  logic [7:0] tail;
  logic [3:0] idx;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_vec = (op == VAMU_OP_SUM) || (op == VAMU_OP_DIFF) ||
                (op == VAMU_OP_PROD);
  wire is_avg = (op == VAMU_OP_BLOCK) || (op == VAMU_OP_WINDOW);
  wire is_scale = (op == VAMU_OP_SCALE);
  wire [17:0] two_m = {1'b0, m, 1'b0};
  wire [17:0] blk_last = two_m + 18'h00002;
  wire in_elem = (state == VAMU_ST_ELEM);
  wire avg_acc = is_avg && (winp || op == VAMU_OP_BLOCK) && (step < two_m);
  wire slide = (op == VAMU_OP_WINDOW) && !winp;
  wire [17:0] last_step = is_vec ? 18'(VAMU_VEC_CYC - 1) :
                          is_scale ? 18'(VAMU_SCALE_CYC - 1) :
                          (op == VAMU_OP_BLOCK) ? blk_last :
                          slide ? 18'(VAMU_SLIDE_CYC - 1) : two_m;
  wire at_last = in_elem && (step == last_step);
  wire [2:0] n_args = is_scale ? 3'h5 : 3'h4;
  wire take_irq = in_elem && (step == 18'h00000) &&
                  irq_req && !(op == VAMU_OP_WINDOW && winp);
  wire signed [15:0] quo;
  wire signed [31:0] prod_full = $signed(xa) * $signed(xb);
  wire signed [31:0] scale_full = $signed(xa) * $signed(konst);
  wire [15:0] sum_v = xa + xb;
  wire [15:0] diff_v = xa - xb;
  wire sum_ovf = (xa[15] == xb[15]) && (sum_v[15] != xa[15]);
  wire diff_ovf = (xa[15] != xb[15]) && (diff_v[15] != xa[15]);
  wire [7:0] tail_len = (op == VAMU_OP_SUM || op == VAMU_OP_DIFF) ?
      8'(VAMU_OVH_SUM - VAMU_FETCH_CYC - 1) :
    (op == VAMU_OP_PROD) ? 8'(VAMU_OVH_PROD - VAMU_FETCH_CYC - 1) :
    (op == VAMU_OP_BLOCK) ? 8'(VAMU_OVH_BLOCK - VAMU_FETCH_CYC - 1) :
    (op == VAMU_OP_WINDOW) ? 8'(VAMU_OVH_WINDOW - VAMU_FETCH_CYC -
                                VAMU_FIRST_WR_CYC - 1) :
    8'(VAMU_OVH_SCALE - VAMU_FETCH_CYC - 1);
  wire [15:0] save_word = (idx == 4'h0) ? {op, winp, 12'h000} :
                          (idx == 4'h1) ? outp :
                          (idx == 4'h2) ? pa :
                          (idx == 4'h3) ? pb :
                          (idx == 4'h4) ? cnt :
                          (idx == 4'h5) ? m :
                          (idx == 4'h6) ? konst : acc;

  // Element quotient for the averaging instructions
  vamu_quot u_quot (
    .num(mem_rdata),
    .den(m),
    .quo(quo)
  );

  // ----------------------------------------------------------------
  // Memory strobes and address
  // ----------------------------------------------------------------
  wire fetch_rd = (state == VAMU_ST_FETCH) && (step < 18'(n_args));
  wire vec_rd = in_elem && is_vec && (step < 18'h00002);
  wire scale_rd = in_elem && is_scale && (step == 18'h00000);
  wire avg_rd = in_elem && avg_acc && !step[0];
  wire slide_rd = in_elem && slide && (step < 18'h00002);
  wire load_rd = (state == VAMU_ST_LOAD) && (idx < VAMU_SAVE_WORDS);
  wire elem_wr = at_last;
  wire save_wr = (state == VAMU_ST_SAVE);
  assign mem_rd = fetch_rd || vec_rd || scale_rd || avg_rd || slide_rd ||
                  load_rd;
  assign mem_wr = elem_wr || save_wr;
  assign mem_addr = (state == VAMU_ST_FETCH) ? ptr_r + step[15:0] :
                    (save_wr || load_rd) ? usp + {12'h000, idx} :
                    mem_wr ? outp :
                    ((vec_rd || slide_rd) && step[0] != slide) ? pb : pa;
  assign mem_wdata = save_wr ? save_word :
                     (is_vec || is_scale) ? res : acc;
  assign busy = (state != VAMU_ST_IDLE);
  assign trace_inhibit = busy;
  assign irq_ack = (state == VAMU_ST_HALT);
  assign done = (state == VAMU_ST_TAIL) && (tail == 8'h00);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= VAMU_ST_IDLE;
      step <= 18'h00000;
      tail <= 8'h00;
      idx <= 4'h0;
    end else if (clk_en) begin
      case (state)
        VAMU_ST_IDLE: begin
          step <= 18'h00000;
          if (start) begin
            state <= VAMU_ST_FETCH;
          end
        end
        VAMU_ST_FETCH: begin
          if (step == 18'(VAMU_FETCH_CYC - 1)) begin
            state <= VAMU_ST_ELEM;
            step <= 18'h00000;
          end else begin
            step <= step + 18'h00001;
          end
        end
        VAMU_ST_ELEM: begin
          if (take_irq) begin
            state <= VAMU_ST_SAVE;
            idx <= 4'h0;
          end else if (at_last) begin
            step <= 18'h00000;
            if ((cnt == 16'h0001 && !(op == VAMU_OP_WINDOW && winp)) ||
                (op == VAMU_OP_WINDOW && winp && cnt == 16'h0000)) begin
              state <= VAMU_ST_TAIL;
              tail <= tail_len;
            end
          end else begin
            step <= step + 18'h00001;
          end
        end
        VAMU_ST_TAIL: begin
          tail <= tail - 8'h01;
          if (tail == 8'h00) begin
            state <= VAMU_ST_IDLE;
          end
        end
        VAMU_ST_SAVE: begin
          idx <= idx + 4'h1;
          if (idx == VAMU_SAVE_WORDS - 4'h1) begin
            state <= VAMU_ST_HALT;
          end
        end
        VAMU_ST_HALT: begin
          idx <= 4'h0;
          if (resume) begin
            state <= VAMU_ST_LOAD;
          end
        end
        VAMU_ST_LOAD: begin
          idx <= idx + 4'h1;
          if (idx == VAMU_SAVE_WORDS) begin
            state <= VAMU_ST_ELEM;
            step <= 18'h00000;
          end
        end
        default: begin
          state <= VAMU_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Argument capture and restore
  // ----------------------------------------------------------------
  wire cap = (state == VAMU_ST_FETCH) && (step != 18'h00000);
  wire [2:0] ai = 3'(step - 18'h00001);
  wire rst_cap = (state == VAMU_ST_LOAD) && (idx != 4'h0);
  wire [3:0] li = idx - 4'h1;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op <= VAMU_OP_SUM;
      ptr_r <= VAMU_WORD_RST;
      outp <= VAMU_WORD_RST;
      pa <= VAMU_WORD_RST;
      pb <= VAMU_WORD_RST;
      cnt <= VAMU_WORD_RST;
      m <= VAMU_WORD_RST;
      konst <= VAMU_WORD_RST;
      winp <= 1'b0;
    end else if (clk_en) begin
      if (state == VAMU_ST_IDLE && start) begin
        op <= opcode;
        ptr_r <= arg_ptr;
      end
      // Argument order differs for scale, and in the third word between vector (pb) and averaging (m)
      if (cap && ai == 3'h0) begin
        outp <= mem_rdata;
      end
      if (cap && ai == 3'h1) begin
        if (is_scale) begin
          konst <= mem_rdata;
        end else begin
          pa <= mem_rdata;
        end
      end
      if (cap && ai == 3'h2) begin
        if (is_vec) begin
          pb <= mem_rdata;
        end else if (is_scale) begin
          pa <= mem_rdata;
        end else begin
          m <= mem_rdata;
        end
      end
      if (cap && ai == 3'h3) begin
        if (is_scale) begin
          m <= mem_rdata;
        end else begin
          cnt <= mem_rdata;
        end
      end
      if (cap && ai == 3'h4 && is_scale) begin
        cnt <= mem_rdata;
      end
      if (state == VAMU_ST_FETCH && step == 18'(VAMU_FETCH_CYC - 1)) begin
        winp <= (op == VAMU_OP_WINDOW);
        if (op == VAMU_OP_WINDOW) begin
          pb <= pa;
          cnt <= cnt - m;
        end
      end
      if (rst_cap) begin
        case (li)
          4'h0: begin
            op <= mem_rdata[15:13];
            winp <= mem_rdata[12];
          end
          4'h1: outp <= mem_rdata;
          4'h2: pa <= mem_rdata;
          4'h3: pb <= mem_rdata;
          4'h4: cnt <= mem_rdata;
          4'h5: m <= mem_rdata;
          4'h6: konst <= mem_rdata;
          default: begin
          end
        endcase
      end
      // An interrupted read is redone after restore, so keep the pointer
      if (avg_rd && !take_irq) begin
        pa <= pa + 16'h0001;
      end
      if (at_last) begin
        if (is_scale) begin
          pa <= pa + m;
          outp <= outp + m;
        end else begin
          outp <= outp + 16'h0001;
        end
        if (is_vec || slide) begin
          pa <= pa + 16'h0001;
          pb <= pb + 16'h0001;
        end
        if (op == VAMU_OP_WINDOW && winp) begin
          winp <= 1'b0;
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  wire cap_a = in_elem && step == 18'h00001 && (is_vec || is_scale);
  wire cap_b = in_elem && step == 18'h00002 && is_vec;
  wire vec_calc = in_elem && step == 18'h00003 && is_vec;
  wire set_ovf = vec_calc && ((op == VAMU_OP_SUM && sum_ovf) ||
                              (op == VAMU_OP_DIFF && diff_ovf));
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xa <= VAMU_WORD_RST;
      xb <= VAMU_WORD_RST;
      res <= VAMU_WORD_RST;
      acc <= VAMU_WORD_RST;
      ovf_flag <= 1'b0;
    end else if (clk_en) begin
      if (cap_a) begin
        xa <= mem_rdata;
      end
      if (cap_b) begin
        xb <= mem_rdata;
      end
      if (vec_calc) begin
        res <= (op == VAMU_OP_SUM) ? sum_v :
               (op == VAMU_OP_DIFF) ? diff_v :
               prod_full[31:16];
      end
      if (in_elem && is_scale && step == 18'h00002) begin
        res <= scale_full[15:0];
      end
      // Set wins over a same-cycle clear
      if (set_ovf) begin
        ovf_flag <= 1'b1;
      end else if (ovf_clr) begin
        ovf_flag <= 1'b0;
      end
      if (state == VAMU_ST_FETCH) begin
        acc <= VAMU_WORD_RST;
      end else if (rst_cap && li == 4'h7) begin
        acc <= mem_rdata;
      end
      if (in_elem && avg_acc && step[0]) begin
        acc <= acc + quo;
      end
      if (at_last && op == VAMU_OP_BLOCK) begin
        acc <= VAMU_WORD_RST;
      end
      if (in_elem && slide && step == 18'h00001) begin
        xb <= quo;
      end
      if (in_elem && slide && step == 18'h00002) begin
        xa <= quo;
      end
      if (in_elem && slide && step == 18'h00003) begin
        acc <= acc - xb + xa;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_fetch_len;
    @(posedge clk) disable iff (!rst_sync_n || !clk_en)
    (state == VAMU_ST_IDLE && start) |=> (state == VAMU_ST_FETCH)[*6];
  endproperty
  a_fetch_len: assert property (p_fetch_len)
    else $error("argument fetch not six cycles");
  property p_fetch_addr;
    @(posedge clk) disable iff (!rst_sync_n || !clk_en)
    (fetch_rd && step != 18'h00000 && $past(clk_en)) |->
      mem_addr == $past(mem_addr) + 16'h0001;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr)
    else $error("argument address not consecutive");
  property p_vec_spacing;
    @(posedge clk) disable iff (!rst_sync_n || !clk_en || irq_req)
    (vec_rd && step == 18'h00000) |-> ##5 (mem_wr && mem_addr == outp);
  endproperty
  a_vec_spacing: assert property (p_vec_spacing)
    else $error("element write not five cycles after read");
  property p_sum_val;
    @(posedge clk) disable iff (!rst_sync_n)
    (at_last && op == VAMU_OP_SUM) |-> mem_wdata == 16'(xa + xb);
  endproperty
  a_sum_val: assert property (p_sum_val)
    else $error("sum written wrong");
  property p_diff_val;
    @(posedge clk) disable iff (!rst_sync_n)
    (at_last && op == VAMU_OP_DIFF) |-> mem_wdata == 16'(xa - xb);
  endproperty
  a_diff_val: assert property (p_diff_val)
    else $error("difference written wrong");
  property p_ovf_set;
    @(posedge clk) disable iff (!rst_sync_n || !clk_en)
    set_ovf |=> ovf_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow not flagged");
  property p_ovf_keep;
    @(posedge clk) disable iff (!rst_sync_n)
    (busy && !is_vec || op == VAMU_OP_PROD) && !ovf_clr |=>
      $stable(ovf_flag);
  endproperty
  a_ovf_keep: assert property (p_ovf_keep)
    else $error("overflow changed by unaffecting op");
  property p_scale_val;
    @(posedge clk) disable iff (!rst_sync_n)
    (at_last && is_scale) |-> mem_wdata == scale_full[15:0];
  endproperty
  a_scale_val: assert property (p_scale_val)
    else $error("scale result wrong");
  property p_trace;
    @(posedge clk) disable iff (!rst_sync_n)
    (mem_rd || mem_wr || irq_ack) |-> trace_inhibit;
  endproperty
  a_trace: assert property (p_trace)
    else $error("trace allowed during instruction");
  property p_save;
    @(posedge clk) disable iff (!rst_sync_n || !clk_en)
    take_irq |=> save_wr [*8] ##1 irq_ack;
  endproperty
  a_save: assert property (p_save)
    else $error("interrupt save sequence wrong");
  property p_slide;
    @(posedge clk) disable iff (!rst_sync_n || !clk_en)
    (in_elem && slide && step == 18'h00003) |=>
      acc == 16'($past(acc) - $past(xb) + $past(xa));
  endproperty
  a_slide: assert property (p_slide)
    else $error("window update wrong");
  c_sum: cover property (@(posedge clk) done && op == VAMU_OP_SUM);
  c_window: cover property (@(posedge clk) done && op == VAMU_OP_WINDOW);
  c_irq: cover property (@(posedge clk) irq_ack ##1 resume);
  c_ovf: cover property (@(posedge clk) set_ovf);
endmodule

/* rtl/vamu_pkg.sv */
// Purpose: Shared constants for the vector arithmetic microcode unit
// Assumes: 16-bit memory words, one memory access per clock
// Notes: Cycle figures are the fixed instruction timings
package vamu_pkg;
  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [2:0] VAMU_OP_SUM = 3'h0;
  localparam logic [2:0] VAMU_OP_DIFF = 3'h1;
  localparam logic [2:0] VAMU_OP_PROD = 3'h2;
  localparam logic [2:0] VAMU_OP_BLOCK = 3'h3;
  localparam logic [2:0] VAMU_OP_WINDOW = 3'h4;
  localparam logic [2:0] VAMU_OP_SCALE = 3'h5;
  // ----------------------------------------------------------------
  // Fixed overhead cycles per instruction
  // ----------------------------------------------------------------
  localparam int VAMU_OVH_SUM = 14;
  localparam int VAMU_OVH_PROD = 16;
  localparam int VAMU_OVH_BLOCK = 35;
  localparam int VAMU_OVH_WINDOW = 39;
  localparam int VAMU_OVH_SCALE = 16;
  // ----------------------------------------------------------------
  // Per-element cycles and sequencing counts
  // ----------------------------------------------------------------
  localparam int VAMU_VEC_CYC = 6;
  localparam int VAMU_SCALE_CYC = 4;
  localparam int VAMU_SLIDE_CYC = 5;
  localparam int VAMU_FETCH_CYC = 6;
  localparam int VAMU_FIRST_WR_CYC = 1;
  localparam logic [3:0] VAMU_SAVE_WORDS = 4'h8;
  localparam logic [15:0] VAMU_WORD_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    VAMU_ST_IDLE = 3'b000,
    VAMU_ST_FETCH = 3'b001,
    VAMU_ST_ELEM = 3'b010,
    VAMU_ST_TAIL = 3'b011,
    VAMU_ST_SAVE = 3'b100,
    VAMU_ST_HALT = 3'b101,
    VAMU_ST_LOAD = 3'b110
  } vamu_state_type;
endpackage

/* rtl/vamu_quot.sv */
// Purpose: Signed quotient of one element by the block or window length
// Assumes: Divisor greater than one in legal use
// Notes: Truncates toward zero; a zero divisor yields zero
module vamu_quot (
  input wire logic signed [15:0] num, // Element value
  input wire logic signed [15:0] den, // Block or window length
  output logic signed [15:0] quo // Truncated quotient
);
  assign quo = (den == 16'sh0000) ? 16'sh0000 : num / den;
endmodule

/* dv/vamu_mem_model.sv */
// Purpose: Memory side of the vector unit, one word per access
// Assumes: Zero wait states, read data one cycle after the strobe
// Notes: Outside a read the data bus toggles so stale words never match
module vamu_mem_model (
  input wire logic clk, // Clock
  input wire logic clk_en, // Stall, freezes memory with the unit
  input wire logic mem_rd, // Read strobe
  input wire logic mem_wr, // Write strobe
  input wire logic [15:0] mem_addr, // Word address
  input wire logic [15:0] mem_wdata, // Write data
  output logic [15:0] mem_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  initial mem_rdata = 16'h0000;
  always @(posedge clk) begin
    if (clk_en) begin
      if (mem_wr) begin
        mem[mem_addr[7:0]] <= mem_wdata;
      end
      // Argument blocks and buffers are served from consecutive words
      if (mem_rd) begin
        mem_rdata <= mem[mem_addr[7:0]];
      end else begin
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule

/* dv/vector_arith_microcode_unit_bench.sv */
// Purpose: Self-checking bench for the vector arithmetic unit
// Assumes: Argument block at 0x10, save area at 0xC0
// Notes: Cycle counts exclude suspended cycles
module vector_arith_microcode_unit_bench import vamu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic irq_req = 1'b0;
  logic resume = 1'b0;
  logic ovf_clr = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] opcode = 3'h0;
  logic [15:0] mem_rdata, mem_addr, mem_wdata;
  logic mem_rd, mem_wr, busy, done, irq_ack, trace_inhibit, ovf_flag;
  int miscompares = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  vamu_core dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .start(start),
    .opcode(opcode), .arg_ptr(16'h0010), .usp(16'h00C0),
    .irq_req(irq_req), .resume(resume), .ovf_clr(ovf_clr),
    .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy), .done(done),
    .irq_ack(irq_ack), .trace_inhibit(trace_inhibit), .ovf_flag(ovf_flag));
  vamu_mem_model mem_model (.clk(clk), .clk_en(clk_en), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put3(input logic [7:0] a, input logic [15:0] w0,
    input logic [15:0] w1, input logic [15:0] w2);
    mem_model.mem[a] = w0;
    mem_model.mem[a + 8'h01] = w1;
    mem_model.mem[a + 8'h02] = w2;
  endtask
  function automatic logic [15:0] rd(input logic [7:0] a);
    return mem_model.mem[a];
  endfunction
  // Issues one instruction, serves any suspension, checks the duration, or with exp_cyc zero that a suspension occurred
  task automatic go(input logic [2:0] op, input int exp_cyc);
    int cyc;
    logic inh_bad;
    logic saw_ack;
    logic saw_done;
    cyc = 0;
    inh_bad = 1'b0;
    saw_ack = 1'b0;
    saw_done = 1'b0;
    @(posedge clk);
    opcode <= op;
    start <= 1'b1;
    repeat (3000) begin
      @(posedge clk);
      start <= 1'b0;
      if (irq_ack === 1'b1) begin
        saw_ack = 1'b1;
        irq_req <= 1'b0;
        resume <= 1'b1;
      end else begin
        resume <= 1'b0;
      end
      if (busy === 1'b1 && irq_ack !== 1'b1 && clk_en === 1'b1) cyc++;
      if (trace_inhibit !== busy) inh_bad = 1'b1;
      if (done === 1'b1) begin
        saw_done = 1'b1;
        break;
      end
    end
    check({15'h0000, saw_done}, 16'h0001);
    check({15'h0000, inh_bad}, 16'h0000);
    if (exp_cyc > 0) check(16'(cyc), 16'(exp_cyc));
    if (exp_cyc == 0) check({15'h0000, saw_ack}, 16'h0001);
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sum;
    put3(8'h10, 16'h0080, 16'h0040, 16'h0060);
    mem_model.mem[8'h13] = 16'h0002;
    put3(8'h40, 16'h7FFF, 16'h0003, 16'h0000);
    put3(8'h60, 16'h0001, 16'hFFFE, 16'h0000);
    go(VAMU_OP_SUM, 26);
    check(rd(8'h80), 16'h8000);
    check(rd(8'h81), 16'h0001);
    check({15'h0000, ovf_flag}, 16'h0001);
    $display("test sum finished");
  endtask
  task automatic t_diff_prod;
    @(posedge clk);
    ovf_clr <= 1'b1;
    @(posedge clk);
    ovf_clr <= 1'b0;
    @(posedge clk);
    check({15'h0000, ovf_flag}, 16'h0000);
    put3(8'h40, 16'h8000, 16'h0005, 16'h0000);
    put3(8'h60, 16'h0001, 16'h0007, 16'h0000);
    go(VAMU_OP_DIFF, 26);
    check(rd(8'h80), 16'h7FFF);
    check(rd(8'h81), 16'hFFFE);
    check({15'h0000, ovf_flag}, 16'h0001);
    put3(8'h40, 16'h4000, 16'hFFFF, 16'h0000);
    put3(8'h60, 16'h4000, 16'h0002, 16'h0000);
    go(VAMU_OP_PROD, 28);
    check(rd(8'h80), 16'h1000);
    check(rd(8'h81), 16'hFFFF);
    check({15'h0000, ovf_flag}, 16'h0001);
    $display("test diff and prod finished");
  endtask
  task automatic t_block_window;
    put3(8'h10, 16'h0080, 16'h0040, 16'h0002);
    put3(8'h40, 16'h0003, 16'h0003, 16'hFFFD);
    mem_model.mem[8'h43] = 16'h0005;
    mem_model.mem[8'h82] = 16'hAAAA;
    go(VAMU_OP_BLOCK, 49);
    check(rd(8'h80), 16'h0002);
    check(rd(8'h81), 16'h0001);
    check(rd(8'h82), 16'hAAAA);
    mem_model.mem[8'h13] = 16'h0003;
    put3(8'h40, 16'h0003, 16'h0005, 16'hFFF9);
    go(VAMU_OP_WINDOW, 48);
    check(rd(8'h80), 16'h0003);
    check(rd(8'h81), 16'hFFFF);
    check(rd(8'h82), 16'hAAAA);
    $display("test block and window finished");
  endtask
  task automatic t_scale;
    put3(8'h10, 16'h0080, 16'h0003, 16'h0040);
    mem_model.mem[8'h13] = 16'h0002;
    mem_model.mem[8'h14] = 16'h0002;
    put3(8'h40, 16'h0002, 16'h0009, 16'hFFFF);
    put3(8'h80, 16'hAAAA, 16'hAAAA, 16'hAAAA);
    go(VAMU_OP_SCALE, 24);
    check(rd(8'h80), 16'h0006);
    check(rd(8'h81), 16'hAAAA);
    check(rd(8'h82), 16'hFFFD);
    // Same run with a five-cycle freeze in mid-instruction
    put3(8'h80, 16'hAAAA, 16'hAAAA, 16'hAAAA);
    fork
      go(VAMU_OP_SCALE, 24);
      begin
        repeat (12) @(posedge clk);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    check(rd(8'h80), 16'h0006);
    check(rd(8'h81), 16'hAAAA);
    check(rd(8'h82), 16'hFFFD);
    $display("test scale finished");
  endtask
  task automatic t_irq;
    put3(8'h10, 16'h0080, 16'h0040, 16'h0060);
    mem_model.mem[8'h13] = 16'h0003;
    put3(8'h40, 16'h0001, 16'h0002, 16'h0003);
    put3(8'h60, 16'h000A, 16'h0014, 16'h001E);
    @(posedge clk);
    irq_req <= 1'b1;
    go(VAMU_OP_SUM, 0);
    check(rd(8'h80), 16'h000B);
    check(rd(8'h81), 16'h0016);
    check(rd(8'h82), 16'h0021);
    $display("test interrupt finished");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_sum();
    t_diff_prod();
    t_block_window();
    t_scale();
    t_irq();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
